// file: rtl/dcd_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants for the dual-channel converter control
// ****************************************************************
package dcd_pkg;
  // Register byte offsets (index times four, printed offsets are not word aligned)
  localparam logic [19:0] DCD_IDX_STANDBY = 20'hee01a;  // Standby control index
  localparam logic [19:0] DCD_IDX_CH0     = 20'hfff9c;  // Channel 0 data index
  localparam logic [19:0] DCD_IDX_CH1     = 20'hfff9d;  // Channel 1 data index
  localparam logic [19:0] DCD_IDX_CTRL    = 20'hfff9e;  // Control index
  localparam logic [21:0] DCD_ADDR_STANDBY = {DCD_IDX_STANDBY, 2'b00};
  localparam logic [21:0] DCD_ADDR_CH0     = {DCD_IDX_CH0, 2'b00};
  localparam logic [21:0] DCD_ADDR_CH1     = {DCD_IDX_CH1, 2'b00};
  localparam logic [21:0] DCD_ADDR_CTRL    = {DCD_IDX_CTRL, 2'b00};
  localparam int          DCD_AW           = 22;          // Decoded address width

  // Reset values
  localparam logic [7:0] DCD_DATA_RST    = 8'h00;
  localparam logic [7:0] DCD_CTRL_RST    = 8'h1f;
  localparam logic [7:0] DCD_STANDBY_RST = 8'hfe;

  // Field positions
  localparam int DCD_CTRL_OE1_BIT = 7;  // Channel 1 output enable
  localparam int DCD_CTRL_OE0_BIT = 6;  // Channel 0 output enable
  localparam int DCD_CTRL_JE_BIT  = 5;  // Joint conversion enable
  localparam int DCD_STBY_KEEP_BIT = 0; // Keep outputs in software standby

  // Writable masks; other bits are fixed ones
  localparam logic [7:0] DCD_CTRL_WMASK = 8'he0;
  localparam logic [7:0] DCD_STBY_WMASK = 8'h01;
endpackage
`default_nettype wire

// file: rtl/dcd_reg8.sv
`default_nettype none
// ****************************************************************
// One 8-bit register with init value, write mask and synchronous init
// ****************************************************************
module dcd_reg8
  import dcd_pkg::*;
#(
  parameter logic [7:0] INIT  = 8'h00,  // Value on reset and on init
  parameter logic [7:0] WMASK = 8'hff   // Bits software can change
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       init,     // Synchronous reinitialise
  input  wire logic       wr,       // Write strobe
  input  wire logic [7:0] wdata,    // Write value
  output var  logic [7:0] value     // Stored value
);
  typedef struct packed {
    logic [7:0] val_reg;
  } dcd_r8_state_t;

  dcd_r8_state_t st_reg;  // Current state
  dcd_r8_state_t st_next; // Next state

  // ****************************************************************
  // Next state: init beats a write in the same cycle
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    if (init)
    begin
      st_next.val_reg = INIT;
    end
    else if (wr)
    begin
      // Fixed bits keep their init value
      st_next.val_reg = (wdata & WMASK) | (INIT & ~WMASK);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '{val_reg: INIT};
    else
      st_reg <= st_next;
  end

  assign value = st_reg.val_reg;
endmodule
`default_nettype wire

// file: rtl/dcd_req_sync.sv
`default_nettype none
// ****************************************************************
// Two-flop synchroniser for a pin level
// ****************************************************************
module dcd_req_sync
  import dcd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,   // Asynchronous level
  output var  logic dout   // Synchronised level
);
  typedef struct packed {
    logic meta_reg;  // First stage, read only by the second
    logic sync_reg;  // Second stage
  } dcd_sync_state_t;

  dcd_sync_state_t st_reg;
  dcd_sync_state_t st_next;

  // Shift chain
  always_comb
  begin
    st_next          = st_reg;
    st_next.meta_reg = din;
    st_next.sync_reg = st_reg.meta_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign dout = st_reg.sync_reg;
endmodule
`default_nettype wire

// file: rtl/dcd_top.sv
// Added by the designer: register access over APB.
`default_nettype none
module dcd_top
  import dcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Standby requests from outside the clock domain
  input  wire logic        soft_standby,   // Software standby level
  input  wire logic        hard_standby,   // Hardware standby level
  // Converter side
  output var  logic        conv_en_ch0,    // Channel 0 conversion running
  output var  logic        conv_en_ch1,    // Channel 1 conversion running
  output var  logic        conv_start_ch0, // One-cycle pulse: new value to convert
  output var  logic        conv_start_ch1, // One-cycle pulse: new value to convert
  output var  logic [7:0]  conv_code_ch0,  // Code presented to channel 0
  output var  logic [7:0]  conv_code_ch1,  // Code presented to channel 1
  output var  logic        analog_out_ch0, // Channel 0 pin driven
  output var  logic        analog_out_ch1  // Channel 1 pin driven
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] rdata_reg;   // Read data
    logic        ready_reg;   // Access answer
    logic        err_reg;     // Unmapped address answer
    logic        en0_reg;     // Conversion enables
    logic        en1_reg;
    logic        start0_reg;  // Conversion start pulses
    logic        start1_reg;
    logic [7:0]  code0_reg;   // Converter codes
    logic [7:0]  code1_reg;
    logic        pin0_reg;    // Pin drive
    logic        pin1_reg;
    logic        soft_d_reg;  // Previous standby level for edge
  } dcd_state_t;

  dcd_state_t st_reg;   // Current state
  dcd_state_t st_next;  // Next state

  logic       soft_s;     // Synchronised software standby
  logic       hard_s;     // Synchronised hardware standby
  logic [7:0] ch0_val;    // Register contents
  logic [7:0] ch1_val;
  logic [7:0] ctrl_val;
  logic [7:0] stby_val;
  logic       access;     // Access phase, first cycle
  logic       wr_ch0;     // Write strobes
  logic       wr_ch1;
  logic       wr_ctrl;
  logic       wr_stby;
  logic       keep;       // Standby keep bit
  logic       soft_entry; // Software standby entry edge
  logic       init_dc;    // Init for data and control
  logic       init_st;    // Init for standby control
  logic       hit;        // Mapped address
  logic       oe0;        // Control bits
  logic       oe1;
  logic       je;
  logic       conv0;      // Derived conversion enables
  logic       conv1;
  logic [21:0] addr;      // Decoded byte address

  // ****************************************************************
  // Standby synchronisers
  // ****************************************************************
  dcd_req_sync u_sync_soft (.clk(clk), .rst(rst), .din(soft_standby), .dout(soft_s));
  dcd_req_sync u_sync_hard (.clk(clk), .rst(rst), .din(hard_standby), .dout(hard_s));

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // One-cycle answer: ready only in the access phase
  assign access  = psel && penable && !st_reg.ready_reg;
  assign addr    = paddr[21:0];
  assign hit     = (addr == DCD_ADDR_CH0) || (addr == DCD_ADDR_CH1) ||
                   (addr == DCD_ADDR_CTRL) || (addr == DCD_ADDR_STANDBY);
  // Writes ignored while hardware standby holds the block
  assign wr_ch0  = access && pwrite && !hard_s && (addr == DCD_ADDR_CH0);
  assign wr_ch1  = access && pwrite && !hard_s && (addr == DCD_ADDR_CH1);
  assign wr_ctrl = access && pwrite && !hard_s && (addr == DCD_ADDR_CTRL);
  assign wr_stby = access && pwrite && !hard_s && (addr == DCD_ADDR_STANDBY);

  // ****************************************************************
  // Standby initialisation
  // ****************************************************************
  assign keep       = stby_val[DCD_STBY_KEEP_BIT];
  assign soft_entry = soft_s && !st_reg.soft_d_reg;
  // Hardware standby always clears; software only without the keep bit
  assign init_dc = hard_s || (soft_entry && !keep);
  assign init_st = hard_s;

  // ****************************************************************
  // Registers
  // ****************************************************************
  dcd_reg8 #(.INIT(DCD_DATA_RST), .WMASK(8'hff)) u_ch0 (
    .clk(clk), .rst(rst), .init(init_dc), .wr(wr_ch0), .wdata(pwdata[7:0]),
    .value(ch0_val));
  dcd_reg8 #(.INIT(DCD_DATA_RST), .WMASK(8'hff)) u_ch1 (
    .clk(clk), .rst(rst), .init(init_dc), .wr(wr_ch1), .wdata(pwdata[7:0]),
    .value(ch1_val));
  dcd_reg8 #(.INIT(DCD_CTRL_RST), .WMASK(DCD_CTRL_WMASK)) u_ctrl (
    .clk(clk), .rst(rst), .init(init_dc), .wr(wr_ctrl), .wdata(pwdata[7:0]),
    .value(ctrl_val));
  dcd_reg8 #(.INIT(DCD_STANDBY_RST), .WMASK(DCD_STBY_WMASK)) u_stby (
    .clk(clk), .rst(rst), .init(init_st), .wr(wr_stby), .wdata(pwdata[7:0]),
    .value(stby_val));

  // ****************************************************************
  // Conversion enables, combinational from registered bits
  // ****************************************************************
  assign oe1 = ctrl_val[DCD_CTRL_OE1_BIT];
  assign oe0 = ctrl_val[DCD_CTRL_OE0_BIT];
  assign je  = ctrl_val[DCD_CTRL_JE_BIT];
  // Both low: none; one high: that one, or both when joint
  assign conv0 = oe0 || (oe1 && je) || (oe1 && oe0);
  assign conv1 = oe1 || (oe0 && je);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next            = st_reg;
    st_next.soft_d_reg = soft_s;
    st_next.ready_reg  = access;
    st_next.err_reg    = access && !hit;
    // Read mux; fixed bits come from the register itself
    if (access && !pwrite)
    begin
      unique case (1'b1)
        addr == DCD_ADDR_CH0:     st_next.rdata_reg = {24'h000000, ch0_val};
        addr == DCD_ADDR_CH1:     st_next.rdata_reg = {24'h000000, ch1_val};
        addr == DCD_ADDR_CTRL:    st_next.rdata_reg = {24'h000000, ctrl_val};
        addr == DCD_ADDR_STANDBY: st_next.rdata_reg = {24'h000000, stby_val};
        default:                  st_next.rdata_reg = 32'h00000000;  // Unmapped
      endcase
    end
    // Enables and pin drives suspended in software standby unless kept
    if (soft_s && !keep)
    begin
      st_next.en0_reg  = 1'b0;
      st_next.en1_reg  = 1'b0;
      st_next.pin0_reg = 1'b0;
      st_next.pin1_reg = 1'b0;
    end
    else
    begin
      st_next.en0_reg  = conv0;
      st_next.en1_reg  = conv1;
      st_next.pin0_reg = oe0;
      st_next.pin1_reg = oe1;
    end
    // Codes always track the data registers
    st_next.code0_reg  = ch0_val;
    st_next.code1_reg  = ch1_val;
    // Start pulse on any change of value, no extra trigger
    st_next.start0_reg = (ch0_val != st_reg.code0_reg);
    st_next.start1_reg = (ch1_val != st_reg.code1_reg);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ****************************************************************
  // Outputs, all from flops
  // ****************************************************************
  assign prdata         = st_reg.rdata_reg;
  assign pready         = st_reg.ready_reg;
  assign pslverr        = st_reg.err_reg;
  assign conv_en_ch0    = st_reg.en0_reg;
  assign conv_en_ch1    = st_reg.en1_reg;
  assign conv_start_ch0 = st_reg.start0_reg;
  assign conv_start_ch1 = st_reg.start1_reg;
  assign conv_code_ch0  = st_reg.code0_reg;
  assign conv_code_ch1  = st_reg.code1_reg;
  assign analog_out_ch0 = st_reg.pin0_reg;
  assign analog_out_ch1 = st_reg.pin1_reg;
endmodule
`default_nettype wire

// file: verif/dcd_top_props.sv
`default_nettype none
// ****************************************************************
// Port-level checks for the converter control block
// ****************************************************************
module dcd_top_props
  import dcd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        soft_standby,
  input wire logic        hard_standby,
  input wire logic        conv_en_ch0,
  input wire logic        conv_en_ch1,
  input wire logic        conv_start_ch0,
  input wire logic        conv_start_ch1,
  input wire logic [7:0]  conv_code_ch0,
  input wire logic [7:0]  conv_code_ch1,
  input wire logic        analog_out_ch0,
  input wire logic        analog_out_ch1
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Completed write, only outside standby so forced states stay out
  logic wr_done;
  logic [7:0] wd;
  assign wr_done = psel && penable && pready && pwrite && !soft_standby && !hard_standby;
  assign wd = pwdata[7:0];
  access_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  err_read_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  en0_follow_a: assert property (wr_done && paddr[21:0] == DCD_ADDR_CTRL
    |-> ##[1:3] conv_en_ch0 == (wd[6] | (wd[7] & wd[5]))) else $error("ch0 enable wrong");
  en1_follow_a: assert property (wr_done && paddr[21:0] == DCD_ADDR_CTRL
    |-> ##[1:3] conv_en_ch1 == (wd[7] | (wd[6] & wd[5]))) else $error("ch1 enable wrong");
  pin_own_a: assert property (wr_done && paddr[21:0] == DCD_ADDR_CTRL
    |-> ##[1:3] {analog_out_ch1, analog_out_ch0} == wd[7:6]) else $error("pin enable wrong");
  code_follow_a: assert property (wr_done && paddr[21:0] == DCD_ADDR_CH0
    |-> ##[1:3] conv_code_ch0 == wd) else $error("ch0 code not presented");
  start_on_change_a: assert property (wr_done && paddr[21:0] == DCD_ADDR_CH1
    && wd != conv_code_ch1 |-> ##[1:3] conv_start_ch1) else $error("ch1 start missing");
  pin_needs_en_a: assert property (analog_out_ch0 |-> conv_en_ch0)
    else $error("ch0 pin driven without conversion");
  c_err: cover property (pslverr);
  c_both: cover property (conv_en_ch0 && conv_en_ch1 && !analog_out_ch1);
  c_keep: cover property (soft_standby && analog_out_ch0);
endmodule
bind dcd_top dcd_top_props u_dcd_top_props (.*);
`default_nettype wire

// file: verif/dcd_top_tb.sv
`default_nettype none
// ****************************************************************
// Self-checking bench: register access, enables, standby
// ****************************************************************
module dcd_top_tb
  import dcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, soft_standby = 0, hard_standby = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic pready, pslverr, en0, en1, st0, st1, pin0, pin1;
  logic [7:0] code0, code1;
  logic [31:0] rd;
  logic err;
  int bad_count = 0, num_checks = 0;
  always #4 clk = ~clk;
  dcd_top u_dcd_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_standby(soft_standby), .hard_standby(hard_standby), .conv_en_ch0(en0),
    .conv_en_ch1(en1), .conv_start_ch0(st0), .conv_start_ch1(st1), .conv_code_ch0(code0),
    .conv_code_ch1(code1), .analog_out_ch0(pin0), .analog_out_ch1(pin1));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; holds the request until ready is sampled high
  task automatic xfer(input logic wr, input logic [21:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pwrite <= wr; paddr <= {10'h0, a}; pwdata <= {24'h0, d}; penable <= 0;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 20)
    begin
      bad_count++;
      $display("[FAIL] %0t ready timeout", $time);
      results();
    end
  endtask
  task automatic rdchk(input logic [21:0] a, input logic [7:0] exp, input string what);
    xfer(0, a, 8'h00);
    chk(rd, {24'h0, exp}, what);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rdchk(DCD_ADDR_CH0, 8'h00, "ch0 init");
    rdchk(DCD_ADDR_CH1, 8'h00, "ch1 init");
    rdchk(DCD_ADDR_CTRL, 8'h1f, "ctrl init");
    rdchk(DCD_ADDR_STANDBY, 8'hfe, "stby init");
    xfer(0, 22'h000100, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset and map done");
    // All eight combinations of the three control bits
    for (int i = 0; i < 8; i++)
    begin
      xfer(1, DCD_ADDR_CTRL, {i[2:0], 5'h00});
      repeat (3) @(posedge clk);
      chk({en1, en0}, {i[2] | (i[1] & i[0]), i[1] | (i[2] & i[0])}, "enables");
      chk({pin1, pin0}, i[2:1], "pins");
      rdchk(DCD_ADDR_CTRL, {i[2:0], 5'h1f}, "ctrl readback");
    end
    $display("test enable table done");
    xfer(1, DCD_ADDR_CH1, 8'h3c);
    xfer(1, DCD_ADDR_CH0, 8'ha5);
    // Start pulse stands in the same cycle the code register takes the new value, one after the data register
    @(posedge clk);
    chk({31'h0, st0}, 32'h1, "ch0 start");
    rdchk(DCD_ADDR_CH1, 8'h3c, "ch1 data");
    chk({24'h0, code0}, 32'ha5, "ch0 code");
    chk({24'h0, code1}, 32'h3c, "ch1 code");
    chk({31'h0, st0}, 32'h0, "ch0 start gone");
    // Software standby without keep clears data and control
    xfer(1, DCD_ADDR_CTRL, 8'hc0);
    soft_standby <= 1;
    repeat (6) @(posedge clk);
    chk({30'h0, pin1, pin0}, 32'h0, "pins off in standby");
    soft_standby <= 0;
    repeat (4) @(posedge clk);
    rdchk(DCD_ADDR_CH0, 8'h00, "ch0 cleared");
    rdchk(DCD_ADDR_CTRL, 8'h1f, "ctrl cleared");
    // With keep set everything survives and pins stay driven
    xfer(1, DCD_ADDR_STANDBY, 8'h01);
    xfer(1, DCD_ADDR_CH0, 8'h5a);
    xfer(1, DCD_ADDR_CTRL, 8'hc0);
    soft_standby <= 1;
    repeat (6) @(posedge clk);
    chk({30'h0, pin1, pin0}, 32'h3, "pins kept");
    soft_standby <= 0;
    repeat (4) @(posedge clk);
    rdchk(DCD_ADDR_CH0, 8'h5a, "ch0 kept");
    rdchk(DCD_ADDR_CTRL, 8'hdf, "ctrl kept");
    rdchk(DCD_ADDR_STANDBY, 8'hff, "stby kept");
    $display("test software standby done");
    // Hardware standby reinitialises all registers, writes ignored
    hard_standby <= 1;
    repeat (4) @(posedge clk);
    xfer(1, DCD_ADDR_CH0, 8'h77);
    hard_standby <= 0;
    repeat (4) @(posedge clk);
    rdchk(DCD_ADDR_STANDBY, 8'hfe, "stby hw init");
    rdchk(DCD_ADDR_CH0, 8'h00, "ch0 hw init");
    $display("test hardware standby done");
    results();
  end
endmodule
`default_nettype wire
